// ### rtl/incr_alu.sv
// eight-bit incrementer with the arithmetic status flags
// assumes purely combinational use; caller latches the result
`timescale 1ns/1ns
module incr_alu
   import jump_incr_pkg::*;
(
   // operand
   input wire logic [7:0] operand,
   // result and flags
   output alu_out_t result
);

   logic [8:0] sum;
   logic [4:0] half;

   // full and low-nibble sums give carry and half carry
   always_comb
   begin
      sum = {1'b0, operand} + 9'h001;
      half = {1'b0, operand[3:0]} + 5'h01;
      result.value = sum[7:0];
      result.flags = '0;
      result.flags[FLAG_C] = sum[8];
      result.flags[FLAG_HALF_CARRY] = half[4];
      result.flags[FLAG_Z] = (sum[7:0] == 8'h00);
      result.flags[FLAG_N] = sum[7];
      // only 7Fh overflows when adding one
      result.flags[FLAG_OVERFLOW] = ~operand[7] & sum[7];
   end

endmodule

// ### rtl/jump_and_increment_exec.sv
// executer for the two-word jump and the one-word register increment
// assumes fetch presents the word at pc and the word after it, same clock,
// and the register file answers a read within one phase (one aclk)
`timescale 1ns/1ns

module jump_and_increment_exec
   import jump_incr_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // program fetch
   output logic [20:0] fetch_pc,
   input wire logic [15:0] fetch_word,
   input wire logic [15:0] fetch_next_word,
   // register file
   output rf_req_t rf_req,
   input wire logic [7:0] rf_rdata
);

   typedef enum logic [0:0]
   {
      ST_EXEC = 1'b0,
      ST_FLUSH = 1'b1
   } exec_state_t;

   typedef enum logic [1:0]
   {
      OP_NONE = 2'b00,
      OP_JUMP = 2'b01,
      OP_INCR = 2'b10
   } op_kind_t;

   // classify a fetched pair of words
   function automatic op_kind_t classify(input logic [15:0] w1, input logic [15:0] w2);
      op_kind_t k;
      k = OP_NONE;
      if (w1[15:8] == JUMP_W1_OP && w2[15:12] == JUMP_W2_OP)
         k = OP_JUMP;
      else if (w1[15:INCR_OP_LSB] == INCR_OP)
         k = OP_INCR;
      return k;
   endfunction

   // resolve the 12-bit data address of a byte instruction
   function automatic logic [11:0] data_addr(input logic [15:0] w, input logic ext,
                                             input logic [3:0] bank, input logic [11:0] idx);
      logic [11:0] a;
      a = {bank, w[7:0]};
      if (!w[BANK_BIT])
      begin
         if (ext && w[7:0] <= INDEXED_LIMIT)
            a = idx + {4'h0, w[7:0]};
         else if (w[7:0] < ACCESS_SPLIT)
            a = {ACCESS_LOW_BANK, w[7:0]};
         else
            a = {ACCESS_HIGH_BANK, w[7:0]};
      end
      return a;
   endfunction

   // registers
   logic [1:0] ctrl_reg;
   logic [3:0] bank_reg;
   logic [11:0] index_reg;
   logic [7:0] work_reg;
   logic [4:0] status_reg;
   logic [20:0] pc_reg;
   exec_state_t state_reg;
   logic [1:0] phase_reg;
   op_kind_t op_reg;
   logic [15:0] ir_reg;
   logic [11:0] jump_hi_reg;
   logic [7:0] jump_lo_reg;
   logic [7:0] operand_reg;
   alu_out_t alu_reg;
   rf_req_t rf_req_reg;

   // bus side
   logic aw_hold_reg, w_hold_reg, awready_reg, wready_reg, bvalid_reg;
   logic [7:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic [1:0] bresp_reg;
   logic arready_reg, rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;

   logic aw_take, w_take, ar_take, do_write, sw_hit;
   logic run;
   alu_out_t alu_now;

   incr_alu u_alu
   (
      .operand(operand_reg),
      .result(alu_now)
   );

   assign aw_take = s_axi_awvalid & awready_reg;
   assign w_take = s_axi_wvalid & wready_reg;
   assign ar_take = s_axi_arvalid & arready_reg;
   assign do_write = aw_hold_reg & w_hold_reg & ~bvalid_reg;
   assign run = ctrl_reg[CTRL_RUN];
   assign sw_hit = do_write & w_strb_reg[0];

   // write address channel: one address held until the write completes
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_hold_reg <= 1'b0;
         awready_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
      end
      else
      begin
         if (aw_take)
         begin
            aw_hold_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         else if (do_write)
            aw_hold_reg <= 1'b0;
         awready_reg <= ~aw_take & ~(aw_hold_reg & ~do_write);
      end
   end

   // write data channel, taken independently of the address
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_hold_reg <= 1'b0;
         wready_reg <= 1'b0;
         w_data_reg <= 32'h00000000;
         w_strb_reg <= 4'h0;
      end
      else
      begin
         if (w_take)
         begin
            w_hold_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         else if (do_write)
            w_hold_reg <= 1'b0;
         wready_reg <= ~w_take & ~(w_hold_reg & ~do_write);
      end
   end

   // write response; unmapped or read-only offsets answer with an error
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
      end
      else if (do_write)
      begin
         bvalid_reg <= 1'b1;
         case (aw_addr_reg)
            OFS_CTRL, OFS_BANK, OFS_INDEX, OFS_WORK: bresp_reg <= RESP_OKAY;
            default: bresp_reg <= RESP_SLVERR;
         endcase
      end
      else if (s_axi_bready)
         bvalid_reg <= 1'b0;
   end

   // software-written configuration; lane 0 gates every write, and the index also needs lane 1
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_reg <= CTRL_RESET;
         bank_reg <= BANK_RESET;
         index_reg <= INDEX_RESET;
      end
      else if (sw_hit)
      begin
         if (aw_addr_reg == OFS_CTRL)
            ctrl_reg <= w_data_reg[1:0];
         if (aw_addr_reg == OFS_BANK)
            bank_reg <= w_data_reg[3:0];
         if (aw_addr_reg == OFS_INDEX && w_strb_reg[1])
            index_reg <= w_data_reg[11:0];
      end
   end

   // read channel: one read at a time, data one cycle after the address
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h00000000;
         rresp_reg <= RESP_OKAY;
      end
      else
      begin
         if (ar_take)
         begin
            rvalid_reg <= 1'b1;
            rresp_reg <= RESP_OKAY;
            case (s_axi_araddr)
               OFS_CTRL: rdata_reg <= {30'h0, ctrl_reg};
               OFS_BANK: rdata_reg <= {28'h0000000, bank_reg};
               OFS_INDEX: rdata_reg <= {20'h00000, index_reg};
               OFS_WORK: rdata_reg <= {24'h000000, work_reg};
               OFS_STATUS: rdata_reg <= {27'h0, status_reg};
               OFS_PC: rdata_reg <= {11'h0, pc_reg};
               default:
               begin
                  rdata_reg <= 32'h00000000;
                  rresp_reg <= RESP_SLVERR;
               end
            endcase
         end
         else if (s_axi_rready)
            rvalid_reg <= 1'b0;
         arready_reg <= ~ar_take & ~(rvalid_reg & ~s_axi_rready);
      end
   end

   // phase counter Q1..Q4, runs only while enabled
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         phase_reg <= PH_Q1;
      else if (run)
         phase_reg <= phase_reg + 2'h1;
   end

   // cycle state: a taken jump is followed by one dead cycle
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         state_reg <= ST_EXEC;
      else if (run && phase_reg == PH_Q4)
      begin
         case (state_reg)
            ST_EXEC: state_reg <= (op_reg == OP_JUMP) ? ST_FLUSH : ST_EXEC;
            ST_FLUSH: state_reg <= ST_EXEC;
            default: state_reg <= ST_EXEC;
         endcase
      end
   end

   // Q1 decode and address setup, Q2 operand read, Q3 process
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         op_reg <= OP_NONE;
         ir_reg <= 16'h0000;
         jump_hi_reg <= 12'h000;
         jump_lo_reg <= 8'h00;
         operand_reg <= 8'h00;
         alu_reg <= '0;
      end
      else if (run && state_reg == ST_EXEC)
      begin
         case (phase_reg)
            PH_Q1:
            begin
               op_reg <= classify(fetch_word, fetch_next_word);
               ir_reg <= fetch_word;
               jump_hi_reg <= fetch_next_word[11:0];
            end
            PH_Q2:
            begin
               jump_lo_reg <= ir_reg[7:0];
               operand_reg <= rf_rdata;
            end
            PH_Q3: alu_reg <= alu_now;
            default: op_reg <= op_reg;
         endcase
      end
      else if (run && phase_reg == PH_Q4)
         op_reg <= OP_NONE;
   end

   // register file port: address from Q1, write strobe only through Q4
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         rf_req_reg <= '0;
      else
      begin
         rf_req_reg.we <= 1'b0;
         if (run && state_reg == ST_EXEC && phase_reg == PH_Q1)
            rf_req_reg.addr <= data_addr(fetch_word, ctrl_reg[CTRL_EXT], bank_reg,
                                         index_reg);
         if (run && state_reg == ST_EXEC && phase_reg == PH_Q3 && op_reg == OP_INCR)
         begin
            rf_req_reg.wdata <= alu_now.value;
            rf_req_reg.we <= ir_reg[DEST_BIT];
         end
      end
   end

   // working register: core write at Q4 wins over a software write
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         work_reg <= WORK_RESET;
      else if (run && state_reg == ST_EXEC && phase_reg == PH_Q4 && op_reg == OP_INCR
               && !ir_reg[DEST_BIT])
         work_reg <= alu_reg.value;
      else if (sw_hit && aw_addr_reg == OFS_WORK)
         work_reg <= w_data_reg[7:0];
   end

   // flags change only on an increment; the jump never touches them
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         status_reg <= STATUS_RESET;
      else if (run && state_reg == ST_EXEC && phase_reg == PH_Q4 && op_reg == OP_INCR)
         status_reg <= alu_reg.flags;
   end

   // program counter written in Q4; held through the dead cycle
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         pc_reg <= PC_RESET;
      else if (run && state_reg == ST_EXEC && phase_reg == PH_Q4)
      begin
         if (op_reg == OP_JUMP)
            pc_reg <= {jump_hi_reg, jump_lo_reg, 1'b0};
         else
            pc_reg <= pc_reg + 21'h000002;
      end
   end

   // outputs straight from flops
   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;
   assign fetch_pc = pc_reg;
   assign rf_req = rf_req_reg;

endmodule

// ### rtl/jump_incr_pkg.sv
// shared constants and carrier types for the jump / increment executer
// assumes a single 100 MHz clock and an AXI4-Lite master for control
package jump_incr_pkg;

   // instruction cycle: four clock phases
   localparam int PHASES_PER_CYCLE = 4;
   localparam logic [1:0] PH_Q1 = 2'h0;
   localparam logic [1:0] PH_Q2 = 2'h1;
   localparam logic [1:0] PH_Q3 = 2'h2;
   localparam logic [1:0] PH_Q4 = 2'h3;

   // opcode fields
   localparam logic [7:0] JUMP_W1_OP = 8'hEF;
   localparam logic [3:0] JUMP_W2_OP = 4'hF;
   localparam logic [5:0] INCR_OP = 6'h0A;
   localparam int INCR_OP_LSB = 10;
   localparam int DEST_BIT = 9;
   localparam int BANK_BIT = 8;

   // data addressing
   localparam logic [7:0] INDEXED_LIMIT = 8'h5F;
   localparam logic [7:0] ACCESS_SPLIT = 8'h60;
   localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
   localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;

   // flag positions in the status register
   localparam int FLAG_C = 0;
   localparam int FLAG_HALF_CARRY = 1;
   localparam int FLAG_Z = 2;
   localparam int FLAG_OVERFLOW = 3;
   localparam int FLAG_N = 4;

   // AXI4-Lite register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_BANK = 8'h04;
   localparam logic [7:0] OFS_INDEX = 8'h08;
   localparam logic [7:0] OFS_WORK = 8'h0C;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_PC = 8'h14;
   localparam int CTRL_RUN = 0;
   localparam int CTRL_EXT = 1;

   // reset values
   localparam logic [1:0] CTRL_RESET = 2'h0;
   localparam logic [3:0] BANK_RESET = 4'h0;
   localparam logic [11:0] INDEX_RESET = 12'h000;
   localparam logic [7:0] WORK_RESET = 8'h00;
   localparam logic [4:0] STATUS_RESET = 5'h00;
   localparam logic [20:0] PC_RESET = 21'h000000;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // register file request towards the core data memory
   typedef struct packed
   {
      logic [11:0] addr;
      logic [7:0] wdata;
      logic we;
   } rf_req_t;

   // increment result with flags
   typedef struct packed
   {
      logic [7:0] value;
      logic [4:0] flags;
   } alu_out_t;

endpackage

// ### verif/jump_incr_properties.sv
// port assertions for the jump / increment executer
// assumes one aclk domain with a synchronous active-low reset
`timescale 1ns/1ns
module jump_incr_properties
   import jump_incr_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // execution side
   input wire logic [20:0] fetch_pc,
   input wire rf_req_t rf_req,
   input wire logic [7:0] rf_rdata
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // pc always holds a word address
   chk_pc_even: assert property (!fetch_pc[0])
      else $error("pc odd");
   // no instruction is shorter than four phases
   chk_pc_spacing: assert property ($changed(fetch_pc) |=> $stable(fetch_pc)[*3])
      else $error("pc moved early");
   // register address only moves at a decode edge
   chk_addr_hold: assert property ($changed(rf_req.addr) |=> $stable(rf_req.addr)[*3])
      else $error("address moved early");
   // after a jump lands, a dead cycle: no write, pc held
   chk_jump_dead: assert property (
      $changed(fetch_pc) && fetch_pc != $past(fetch_pc) + 21'h2
      |=> (!rf_req.we && $stable(fetch_pc))[*6])
      else $error("activity in jump dead cycle");
   // write strobe, address and data of the write-back, and the pc step after it
   chk_we_pulse: assert property (rf_req.we |=> !rf_req.we)
      else $error("write strobe too long");
   chk_we_addr: assert property (rf_req.we |-> rf_req.addr == $past(rf_req.addr, 2))
      else $error("write address moved");
   chk_incr_data: assert property (rf_req.we |-> rf_req.wdata == $past(rf_rdata) + 8'h01)
      else $error("write data not read plus one");
   chk_we_pc_step: assert property (rf_req.we |=> fetch_pc == $past(fetch_pc) + 21'h2)
      else $error("pc not stepped after write");
   // main scenarios
   cover property (rf_req.we);
   cover property ($changed(fetch_pc) && fetch_pc != $past(fetch_pc) + 21'h2);
   cover property ($changed(rf_req.addr));
endmodule
bind jump_and_increment_exec jump_incr_properties chk
(
   .aclk(aclk), .aresetn(aresetn), .fetch_pc(fetch_pc), .rf_req(rf_req), .rf_rdata(rf_rdata)
);

// ### verif/prog_regfile_model.sv
// program memory and core register file for the executer
// assumes the bench loads prog and mem before the core reaches those words; it may patch them while run is set
`timescale 1ns/1ns
module prog_regfile_model
   import jump_incr_pkg::*;
(
   // clock
   input wire logic aclk,
   // program fetch
   input wire logic [20:0] fetch_pc,
   output logic [15:0] fetch_word,
   output logic [15:0] fetch_next_word,
   // register file
   input wire rf_req_t rf_req,
   output logic [7:0] rf_rdata
);
   logic [15:0] prog [int];
   logic [7:0] mem [4096];

   // empty program words read as zero, an unknown opcode
   function automatic logic [15:0] word_at(input int i);
      return prog.exists(i) ? prog[i] : 16'h0000;
   endfunction

   // defined values before the first clock
   initial
   begin
      fetch_word = 16'h0000;
      fetch_next_word = 16'h0000;
      rf_rdata = 8'h00;
   end

   // refresh mid-cycle, so a program patched in place is seen too
   always @(negedge aclk)
   begin
      fetch_word <= word_at(int'(fetch_pc[20:1]));
      fetch_next_word <= word_at(int'(fetch_pc[20:1]) + 1);
      rf_rdata <= mem[rf_req.addr];
   end

   // write-back on the edge that closes the write phase
   always @(posedge aclk)
   begin
      if (rf_req.we === 1'b1)
         mem[rf_req.addr] <= rf_req.wdata;
   end
endmodule

// ### verif/testbench.sv
// self-checking bench for the jump / increment executer
// assumes the partner model holds program memory and register file
`timescale 1ns/1ns
module testbench import jump_incr_pkg::*;;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, rf_rdata;
   logic [31:0] wdata = 32'h0, rdata;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [20:0] fetch_pc;
   logic [15:0] fetch_word, fetch_next_word;
   rf_req_t rf_req;
   int num_errors = 0, cmp_count = 0, n;

   jump_and_increment_exec dut
   (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .fetch_pc(fetch_pc), .fetch_word(fetch_word), .fetch_next_word(fetch_next_word),
      .rf_req(rf_req), .rf_rdata(rf_rdata)
   );
   prog_regfile_model model
   (
      .aclk(aclk), .fetch_pc(fetch_pc), .fetch_word(fetch_word),
      .fetch_next_word(fetch_next_word), .rf_req(rf_req), .rf_rdata(rf_rdata)
   );

   // 100 MHz clock
   initial
   begin
      forever #5 aclk = ~aclk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   // offer address and data together, release each when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (int i = 0; i < 64; i++)
      begin
         @(posedge aclk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
         if (bvalid)
            break;
      end
      bready <= 1'b0;
      check(bvalid, 1'b1);
      check(bresp, er);
   endtask

   // read one register, compare data and response
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int i = 0; i < 64; i++)
      begin
         @(posedge aclk);
         if (arready)
            arvalid <= 1'b0;
         if (rvalid)
            break;
      end
      rready <= 1'b0;
      check(rvalid, 1'b1);
      check(rdata, exp);
      check(rresp, er);
   endtask

   // sampled mid-cycle, away from the edge that moves pc
   task automatic wait_pc(input logic [20:0] target, output int cycles);
      cycles = 0;
      do
      begin
         @(negedge aclk);
         cycles++;
      end
      while (fetch_pc !== target && cycles < 400);
      check(fetch_pc, target);
   endtask

   // reset values, an unmapped place and a read-only write
   task automatic test_regs();
      for (int a = 0; a < 24; a += 4)
         rd(8'(a), 32'h0, RESP_OKAY);
      rd(8'h40, 32'h0, RESP_SLVERR);
      wr(OFS_STATUS, 32'h1F, RESP_SLVERR);
      rd(OFS_STATUS, 32'h0, RESP_OKAY);
      $display("test_regs finished");
   endtask

   // foreign opcode, then a banked increment into the working register
   task automatic test_incr_w();
      model.mem[12'h312] = 8'h7F;
      model.prog[0] = 16'h2D12;
      model.prog[1] = 16'h2912;
      model.prog[2] = 16'hEF02;
      model.prog[3] = 16'hF000;
      wr(OFS_BANK, 32'h3, RESP_OKAY);
      wr(OFS_INDEX, 32'h200, RESP_OKAY);
      wr(OFS_CTRL, 32'h3, RESP_OKAY);
      wait_pc(21'h4, n);
      repeat (16) @(posedge aclk);
      rd(OFS_WORK, 32'h80, RESP_OKAY);
      rd(OFS_STATUS, 32'h1A, RESP_OKAY);
      check(model.mem[12'h312], 32'h7F);
      $display("test_incr_w finished");
   endtask

   // far jump patched into the parked loop, then indexed and access-bank increments
   task automatic test_jump();
      model.mem[12'h210] = 8'h8F;
      model.mem[12'h010] = 8'h11;
      model.mem[12'hF60] = 8'hFF;
      model.prog[32'h12345] = 16'h2A10;
      model.prog[32'h12346] = 16'h2A60;
      model.prog[32'h12347] = 16'hEF47;
      model.prog[32'h12348] = 16'hF123;
      model.prog[2] = 16'hEF45;
      model.prog[3] = 16'hF123;
      wait_pc(21'h2468A, n);
      wait_pc(21'h2468C, n);
      check(n, 8);
      wait_pc(21'h2468E, n);
      check(n, 4);
      repeat (24) @(posedge aclk);
      rd(OFS_PC, 32'h2468E, RESP_OKAY);
      rd(OFS_STATUS, 32'h07, RESP_OKAY);
      rd(OFS_WORK, 32'h80, RESP_OKAY);
      check(model.mem[12'h210], 32'h90);
      check(model.mem[12'h010], 32'h11);
      check(model.mem[12'hF60], 32'h00);
      $display("test_jump finished");
   endtask

   // extended set off: a low address stays in the access bank despite bank 3
   task automatic test_access_bank();
      wr(OFS_CTRL, 32'h1, RESP_OKAY);
      model.prog[32'h12347] = 16'h2A10;
      wait_pc(21'h24690, n);
      repeat (8) @(posedge aclk);
      check(model.mem[12'h010], 32'h12);
      check(model.mem[12'h310], 32'h00);
      rd(OFS_STATUS, 32'h00, RESP_OKAY);
      $display("test_access_bank finished");
   endtask

   task automatic give_verdict();
      $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // reset, then the scenarios in turn
   initial
   begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      test_regs();
      test_incr_w();
      test_jump();
      test_access_bank();
      give_verdict();
   end

   // the scenarios need well under 2000 cycles
   initial
   begin
      repeat (20000) @(posedge aclk);
      num_errors++;
      give_verdict();
   end
endmodule
